// ===== bench/ecf_chk.sv
// Port checker for the cam follower
`include "ecf_map.vh"
module ecf_chk (
  input wire               i_clk,
  input wire               i_rst_n,
  input wire               i_ce,
  input wire               i_proc_mode,
  input wire               i_cam_enable_field,
  input wire [2:0]         i_master_source_select,
  input wire [1:0]         i_capture_source_field,
  input wire [9:0]         i_curve_division_count,
  input wire               i_mpos_wr,
  input wire [31:0]        i_mpos_wdata,
  input wire [31:0]        i_area_lo,
  input wire [31:0]        i_area_hi,
  input wire [4:0]         i_do_func,
  input wire               i_cap_step,
  input wire               i_sync_capture_axis_param,
  input wire signed [31:0] i_proc_inc,
  input wire signed [31:0] o_pos_cmd_inc,
  input wire [1:0]         o_cam_state,
  input wire [31:0]        o_master_position_monitor,
  input wire               o_div_err,
  input wire               o_do
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire run = i_ce && i_proc_mode && i_cam_enable_field;
  wire div_ok = i_curve_division_count >= `ECF_DIV_MIN && i_curve_division_count <= `ECF_DIV_MAX;
  wire [31:0] mp = o_master_position_monitor;
  wire area = i_do_func == `ECF_DO_CAM_AREA && mp >= i_area_lo && mp <= i_area_hi;
  sequence s_arm;
    o_cam_state == `ECF_ST_STOP && run && div_ok && !o_div_err;
  endsequence
  sequence s_hit;
    o_cam_state == `ECF_ST_LEAD && run && i_master_source_select == `ECF_SRC_CAPTURE
      && i_capture_source_field == 2'h0 && i_cap_step && !i_mpos_wr;
  endsequence
  chk_mode_gate: assert property (i_ce && !i_proc_mode |-> ##2 o_cam_state == `ECF_ST_STOP)
    else $error("cam left stop outside procedure mode");
  chk_off_stops: assert property (i_ce && !i_cam_enable_field |-> ##2 o_cam_state == `ECF_ST_STOP)
    else $error("cam not stopped while disabled");
  chk_arm_lead: assert property (s_arm ##1 s_arm |=> o_cam_state == `ECF_ST_LEAD)
    else $error("enable did not reach lead state");
  chk_state_legal: assert property (o_cam_state != 2'h3)
    else $error("illegal cam state");
  chk_lead_engage: assert property (s_hit |-> ##2 o_cam_state == `ECF_ST_ENGAGED)
    else $error("master step did not engage");
  chk_idle_sum: assert property (i_ce && o_cam_state == `ECF_ST_STOP |=> o_pos_cmd_inc == $past(i_proc_inc))
    else $error("stopped command is not the procedure term");
  chk_div_range: assert property (i_ce && !div_ok |-> ##[1:2] o_div_err)
    else $error("bad division count not flagged");
  chk_mon_load: assert property (i_ce && i_mpos_wr ##1 o_cam_state != `ECF_ST_ENGAGED
    |-> mp == $past(i_mpos_wdata))
    else $error("master position load lost");
  chk_step_count: assert property (run && div_ok && o_cam_state != `ECF_ST_STOP && !i_mpos_wr
    && i_master_source_select == `ECF_SRC_SYNCCAP && i_sync_capture_axis_param
    |=> mp == $past(mp) + 32'h1)
    else $error("master step not counted");
  chk_area_set: assert property (area ##1 area |=> o_do)
    else $error("area output low inside area");
  chk_area_clear: assert property (!area ##1 !area |=> !o_do)
    else $error("area output high outside area");
endmodule

// ===== bench/ecf_partner.sv
// Far side model: step pins, curve array, position loop sum
module ecf_partner #(
  parameter AW = 10                         // Array index width
) (
  input  wire                 i_clk,        // Clock
  input  wire                 i_rst_n,      // Reset, active low
  input  wire [1:0]           i_go,         // Request one pin step
  input  wire [AW-1:0]        i_addr,       // Curve index
  input  wire signed [31:0]   i_inc,        // Command increment
  output logic [1:0]          o_pin,        // Encoder, pulse pins
  output logic signed [31:0]  o_rdata,      // Curve word
  output logic signed [31:0]  o_pos         // Summed command
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt [2] = '{3'h0, 3'h0};
  // Pins idle low, high long enough to pass the filter
  always @(posedge i_clk) begin
    for (int k = 0; k < 2; k++)
      cnt[k] <= i_go[k] ? 3'h6 : cnt[k] - 3'(cnt[k] != 3'h0);
    o_rdata <= -32'sh40 * $signed({1'b0, i_addr});
  end
  assign o_pin = {cnt[1] != 3'h0, cnt[0] != 3'h0};
  always @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      o_pos <= 32'sh0;
    else
      o_pos <= o_pos + i_inc;
endmodule

// ===== bench/tb.sv
// Bench for the cam follower
`include "ecf_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, ce = 1, proc = 0, en = 0, wr = 0, cap = 0, sync = 0, ana = 0, err, dout;
  logic [1:0] go = 0, capf = 0, pin, cst;
  logic [2:0] src = 0;
  logic [9:0] div = 10'h010, eng = 10'h003, addr;
  logic [31:0] wdat = 0, mon, mon0;
  logic signed [31:0] pinc = 0, rdat, cmd, pos;
  int n_mismatch = 0, total_checks = 0;
  always #2.5 clk = ~clk;
  ecf_cam_follower #(.TICK_CYC(20)) dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_proc_mode(proc),
    .i_cam_enable_field(en), .i_master_source_select(src), .i_capture_source_field(capf),
    .i_curve_start_index(10'h020), .i_curve_division_count(div), .i_engage_point_param(eng),
    .i_mpos_wr(wr), .i_mpos_wdata(wdat), .i_area_lo(32'h00000064), .i_area_hi(32'h00000068),
    .i_do_func(5'h18), .i_linear_encoder_port(pin[0]), .i_pulse_command_port(pin[1]), .i_cap_step(cap),
    .i_sync_capture_axis_param(sync), .i_analog_step(ana), .i_proc_inc(pinc), .i_array_rdata(rdat),
    .o_array_addr(addr), .o_pos_cmd_inc(cmd), .o_cam_state(cst), .o_master_position_monitor(mon),
    .o_div_err(err), .o_do(dout));
  ecf_partner u_far (.i_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_addr(addr), .i_inc(cmd),
    .o_pin(pin), .o_rdata(rdat), .o_pos(pos));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    case (k)
      0: cap <= 1;
      1: go <= 2'h1;
      2: go <= 2'h2;
      3: pinc <= 32'sh1;
      5: sync <= 1;
      6: ana <= 1;
      default: ;
    endcase
    @(posedge clk);
    {cap, sync, ana, go} <= 5'h0;
    pinc <= 0;
    w(10);
  endtask
  initial begin
    w(10);
    rst_n <= 1;
    w(2);
    chk("state", 32'(cst), 32'h0);
    @(posedge clk);
    proc <= 1;
    pinc <= 32'sh7;
    @(posedge clk);
    pinc <= -32'sh3;
    @(posedge clk);
    pinc <= 0;
    w(3);
    chk("position", pos, 32'h4);
    @(posedge clk);
    proc <= 0;
    en <= 1;
    w(3);
    chk("state", 32'(cst), 32'h0);
    @(posedge clk);
    proc <= 1;
    div <= 10'h004;
    w(3);
    chk("state", 32'(cst), 32'h0);
    chk("div error", 32'(err), 32'h1);
    @(posedge clk);
    en <= 0;
    div <= `ECF_DIV_MAX;
    wr <= 1;
    wdat <= 32'h64;
    @(posedge clk);
    wr <= 0;
    w(3);
    chk("div error", 32'(err), 32'h0);
    chk("monitor", mon, 32'h64);
    chk("position", pos, 32'h4);
    chk("area out", 32'(dout), 32'h1);
    @(posedge clk);
    en <= 1;
    w(2);
    chk("state", 32'(cst), 32'h1);
    for (int s = 0; s < 7; s++) begin
      src <= 3'(s);
      w(2);
      mon0 = mon;
      for (int k = 0; k < 7; k++)
        if (k != s && s != 4) pulse(k);
      chk("foreign step", mon, s == 4 ? mon : mon0);
      mon0 = mon;
      if (s == 4) w(40);
      else pulse(s);
      chk("own step", mon - mon0, s == 4 ? 32'h2 : 32'h1);
    end
    chk("state", 32'(cst), 32'h2);
    chk("array index", 32'(addr >= 10'h020 && addr <= 10'h2F0), 32'h1);
    mon0 = mon;
    ce <= 0;
    pulse(6);
    chk("frozen monitor", mon, mon0);
    ce <= 1;
    mon0 = mon;
    @(posedge clk);
    src <= 0;
    capf <= 2'h1;
    pulse(1);
    chk("capture step", mon - mon0, 32'h1);
    chk("area out", 32'(dout), 32'h0);
    @(posedge clk);
    en <= 0;
    w(2);
    chk("state", 32'(cst), 32'h0);
    stop_test;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    stop_test;
  end
endmodule
bind ecf_cam_follower ecf_chk u_chk (.i_clk, .i_rst_n, .i_ce, .i_proc_mode, .i_cam_enable_field,
  .i_master_source_select, .i_capture_source_field, .i_curve_division_count, .i_mpos_wr, .i_mpos_wdata,
  .i_area_lo, .i_area_hi, .i_do_func, .i_cap_step, .i_sync_capture_axis_param, .i_proc_inc,
  .o_pos_cmd_inc, .o_cam_state, .o_master_position_monitor, .o_div_err, .o_do);

// ===== rtl/ecf_cam_follower.v
// Electronic cam follower: master select, curve lookup, interpolation, command sum
// Summary of operation
// - Cam runs only while the drive is in procedure register mode.
// - Enable at zero, the default, turns cam off and disengages at once.
// - Enable written one switches the cam function on.
// - Cam state is one of stopped, lead pulse, engaged.
// - Source one is linear encoder, two is pulse command input.
// - Source zero follows the capture source chosen by capture field.
// - Source three is procedure command, four is a 1 ms tick.
// - Source five is synchronous capture axis, six is analog channel one.
// - Servo command equals cam output plus procedure command.
// - Cam output contributes only while engaged.
// - Procedure term always valid, except zeroed when it drives the engaged cam.
// - Procedure increments still trim the slave while the cam runs.
// - Curve read from data array at start index, division count plus one entries.
// - Engage point parameter sets the curve point where engagement starts.
// - Division count taken from parameter, valid range 5 to 720.
// - Curve entries are signed 32-bit two's complement values.
// - Curve entries hold slave position in user position units.
// - Master pulses accumulate incrementally into the cam axis.
// - Slave output leaves as increments into the position command path.
// - No forced return to start after a revolution; curve decides.
// - Segments between points interpolated with smooth quadratic ends.
// - Cam area output asserts while master position is inside the area.
// - Enabled cam counts master pulses; monitor writable before engaging.
`include "ecf_map.vh"
module ecf_cam_follower #(
  parameter AW        = 10,                   // Data array address width
  parameter FW        = 8,                    // Fraction bits per curve point
  parameter TICK_CYC  = `ECF_TICK_CYCLES      // Cycles per 1 ms tick
) (
  input  wire                 i_clk,          // System clock 200 MHz
  input  wire                 i_rst_n,        // Async reset, active low
  input  wire                 i_ce,           // Clock enable, freezes state when low
  input  wire                 i_proc_mode,    // Drive in procedure register mode
  input  wire                 i_cam_enable_field,   // Cam enable
  input  wire [2:0]           i_master_source_select, // Master axis source
  input  wire [1:0]           i_capture_source_field, // Capture source pick
  input  wire [AW-1:0]        i_curve_start_index,    // Curve start in data array
  input  wire [9:0]           i_curve_division_count, // Divisions 5..720
  input  wire [9:0]           i_engage_point_param,   // Engage curve point
  input  wire                 i_mpos_wr,      // Master position monitor write
  input  wire [31:0]          i_mpos_wdata,   // Master position write value
  input  wire [31:0]          i_area_lo,      // Cam area low bound
  input  wire [31:0]          i_area_hi,      // Cam area high bound
  input  wire [4:0]           i_do_func,      // Digital output function code
  input  wire                 i_linear_encoder_port, // Encoder step pin
  input  wire                 i_pulse_command_port,  // Pulse command step pin
  input  wire                 i_cap_step,     // Capture axis step, same clock
  input  wire                 i_sync_capture_axis_param, // Sync capture step, same clock
  input  wire                 i_analog_step,  // Analog channel 1 step, same clock
  input  wire signed [31:0]   i_proc_inc,     // Procedure position increment
  input  wire signed [31:0]   i_array_rdata,  // Data array read data, one cycle
  output reg  [AW-1:0]        o_array_addr,   // Data array read index
  output reg  signed [31:0]   o_pos_cmd_inc,  // Position command increment to loop
  output reg  [1:0]           o_cam_state,    // Cam state
  output reg  [31:0]          o_master_position_monitor, // Master position
  output reg                  o_div_err,      // Division count out of range
  output reg                  o_do                // Cam area digital output
);

  localparam NPIN = 2;                        // Step pins: encoder, pulse command
  localparam EW   = 2 * FW + 2;               // Ease product width

  // State codes
  localparam [1:0] ST_STOP     = `ECF_ST_STOP;
  localparam [1:0] ST_LEAD     = `ECF_ST_LEAD;
  localparam [1:0] ST_ENGAGED  = `ECF_ST_ENGAGED;
  // Master source codes
  localparam [2:0] SRC_CAPTURE = `ECF_SRC_CAPTURE;
  localparam [2:0] SRC_LINENC  = `ECF_SRC_LINENC;
  localparam [2:0] SRC_PULSE   = `ECF_SRC_PULSE;
  localparam [2:0] SRC_PROC    = `ECF_SRC_PROC;
  localparam [2:0] SRC_TICK    = `ECF_SRC_TICK;
  localparam [2:0] SRC_SYNCCAP = `ECF_SRC_SYNCCAP;
  localparam [2:0] SRC_ANALOG  = `ECF_SRC_ANALOG;

  genvar             gi;
  wire [NPIN-1:0]    pin_in;
  wire [NPIN-1:0]    pin_step;
  reg  [31:0]        tick_cnt_q;
  reg                tick_q;
  wire               tick_end;
  reg  [1:0]         state_q;
  reg  [1:0]         state_d;
  reg  [9:0]         idx_q;
  reg  [9:0]         idx_d;
  reg  [FW-1:0]      frac_q;
  reg  [FW-1:0]      frac_d;
  reg  [31:0]        mpos_d;
  reg  [1:0]         fetch_q;
  reg  [AW-1:0]      base_q;
  reg  signed [31:0] p0_q;
  reg  signed [31:0] p1_q;
  reg  signed [31:0] slave_q;
  reg                step;
  wire               div_ok;
  wire               run;
  wire               engaged;
  wire               load_en;
  wire               cnt_en;
  wire               last_idx;
  wire [AW-1:0]      pt_addr;
  wire [FW:0]        f1;
  wire [FW:0]        f_rev;
  wire [EW-1:0]      sq_lo;
  wire [EW-1:0]      sq_hi;
  wire [EW-1:0]      full;
  wire [EW-1:0]      ease;
  wire signed [31:0] span;
  wire signed [63:0] diff_w;
  wire signed [31:0] interp;
  wire signed [31:0] cam_term;
  wire signed [31:0] proc_term;
  wire signed [31:0] pos_cmd_d;
  wire               area_hit;
  wire               do_d;

  assign pin_in = {i_pulse_command_port, i_linear_encoder_port};

  // Three flops per pin; a level counts once the last two agree
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_pin
      reg  [2:0] sy_q;
      reg        lv_q;
      wire       agree;
      assign agree = (sy_q[1] == sy_q[2]);
      always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          sy_q <= 3'h0;
          lv_q <= 1'h0;
        end else if (i_ce) begin
          sy_q <= {sy_q[1:0], pin_in[gi]};
          if (agree)
            lv_q <= sy_q[2];
        end
      end
      // Rising edge of the agreed level
      assign pin_step[gi] = agree && sy_q[2] && !lv_q;
    end
  endgenerate

  assign tick_end = (tick_cnt_q == TICK_CYC - 1);
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt_q <= 32'h00000000;
      tick_q     <= 1'h0;
    end else if (i_ce) begin
      tick_q <= tick_end;
      if (tick_end)
        tick_cnt_q <= 32'h00000000;
      else
        tick_cnt_q <= tick_cnt_q + 32'h00000001;
    end
  end

  always @* begin
    case (i_master_source_select)
      SRC_CAPTURE: begin
        case (i_capture_source_field)
          2'h1:    step = pin_step[0];
          2'h2:    step = pin_step[1];
          default: step = i_cap_step;
        endcase
      end
      SRC_LINENC:  step = pin_step[0];
      SRC_PULSE:   step = pin_step[1];
      SRC_PROC:    step = (i_proc_inc != 32'sh00000000);
      SRC_TICK:    step = tick_q;
      SRC_SYNCCAP: step = i_sync_capture_axis_param;
      SRC_ANALOG:  step = i_analog_step;
      default:     step = 1'h0;
    endcase
  end

  assign div_ok   = (i_curve_division_count >= `ECF_DIV_MIN) &&
                    (i_curve_division_count <= `ECF_DIV_MAX);
  assign run      = i_proc_mode && (i_cam_enable_field == `ECF_EN_ON) && div_ok;
  assign engaged  = (state_q == ST_ENGAGED);
  // a monitor write wins over a step until engaged
  assign load_en  = i_mpos_wr && !engaged;
  assign cnt_en   = run && step && !load_en;
  assign last_idx = (idx_q == i_curve_division_count - 10'h001);

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_STOP: begin
        if (run)
          state_d = ST_LEAD;
      end
      ST_LEAD: begin
        if (step && !i_mpos_wr)
          state_d = ST_ENGAGED;
      end
      ST_ENGAGED: begin
        state_d = ST_ENGAGED;
      end
      default: begin
        state_d = ST_STOP;
      end
    endcase
    if (!run)
      state_d = ST_STOP;
  end

  // index and fraction, wrapping at the division count
  always @* begin
    idx_d  = idx_q;
    frac_d = frac_q;
    if (run && state_q == ST_STOP) begin
      idx_d  = i_engage_point_param;
      frac_d = {FW{1'b0}};
    end else if (cnt_en && engaged) begin
      frac_d = frac_q + {{(FW-1){1'b0}}, 1'b1};
      if (&frac_q) begin
        if (last_idx)
          idx_d = 10'h000;
        else
          idx_d = idx_q + 10'h001;
      end
    end
  end

  always @* begin
    mpos_d = o_master_position_monitor;
    if (load_en)
      mpos_d = i_mpos_wdata;
    else if (cnt_en)
      mpos_d = o_master_position_monitor + 32'h00000001;
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      state_q <= ST_STOP;
    else if (i_ce)
      state_q <= state_d;
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idx_q  <= 10'h000;
      frac_q <= {FW{1'b0}};
    end else if (i_ce) begin
      idx_q  <= idx_d;
      frac_q <= frac_d;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      o_master_position_monitor <= `ECF_MPOS_RST;
    else if (i_ce)
      o_master_position_monitor <= mpos_d;
  end

  // curve fetch, two points per segment
  assign pt_addr = base_q + idx_q[AW-1:0];
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fetch_q      <= 2'h0;
      o_array_addr <= {AW{1'b0}};
      p0_q         <= 32'sh00000000;
      p1_q         <= 32'sh00000000;
      base_q       <= {AW{1'b0}};
    end else if (i_ce) begin
      base_q  <= i_curve_start_index;
      fetch_q <= fetch_q + 2'h1;
      case (fetch_q)
        2'h0:    o_array_addr <= pt_addr;
        2'h1:    o_array_addr <= pt_addr + {{(AW-1){1'b0}}, 1'b1};
        2'h2:    p0_q         <= i_array_rdata;
        default: p1_q         <= i_array_rdata;
      endcase
    end
  end

  // two quadratic halves, slope continuous at the middle
  assign f1     = {1'b0, frac_q};
  assign f_rev  = {1'b1, {FW{1'b0}}} - f1;
  assign sq_lo  = {{FW{1'b0}}, f1, 1'b0} * {{(FW+1){1'b0}}, f1};
  assign sq_hi  = {{FW{1'b0}}, f_rev, 1'b0} * {{(FW+1){1'b0}}, f_rev};
  assign full   = {2'b01, {(2*FW){1'b0}}};
  assign ease   = frac_q[FW-1] ? (full - sq_hi) : sq_lo;
  assign span   = p1_q - p0_q;
  assign diff_w = $signed({{32{span[31]}}, span}) * $signed({{(64-EW){1'b0}}, ease});
  assign interp = p0_q + diff_w[2*FW+31:2*FW];

  // slave increment from curve, no forced return
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      slave_q <= 32'sh00000000;
    else if (i_ce && fetch_q == 2'h0)
      slave_q <= interp;
  end

  assign cam_term  = engaged ? (interp - slave_q) : 32'sh00000000;
  assign proc_term = (engaged && i_master_source_select == SRC_PROC) ?
                     32'sh00000000 : i_proc_inc;
  // cam increment once per fetch loop
  assign pos_cmd_d = (fetch_q == 2'h0 ? cam_term : 32'sh00000000) + proc_term;
  assign area_hit  = (o_master_position_monitor >= i_area_lo) &&
                     (o_master_position_monitor <= i_area_hi);
  assign do_d      = (i_do_func == `ECF_DO_CAM_AREA) && area_hit;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pos_cmd_inc <= 32'sh00000000;
      o_do          <= 1'h0;
    end else if (i_ce) begin
      o_pos_cmd_inc <= pos_cmd_d;
      o_do          <= do_d;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cam_state <= ST_STOP;
      o_div_err   <= 1'h0;
    end else if (i_ce) begin
      o_cam_state <= state_q;
      o_div_err   <= !div_ok;
    end
  end

endmodule

// ===== rtl/ecf_map.vh
// Constants for the electronic cam follower
`ifndef ECF_MAP_VH
`define ECF_MAP_VH
`define ECF_EN_OFF        1'h0
`define ECF_EN_ON         1'h1
`define ECF_SRC_CAPTURE   3'h0
`define ECF_SRC_LINENC    3'h1
`define ECF_SRC_PULSE     3'h2
`define ECF_SRC_PROC      3'h3
`define ECF_SRC_TICK      3'h4
`define ECF_SRC_SYNCCAP   3'h5
`define ECF_SRC_ANALOG    3'h6
`define ECF_ST_STOP       2'h0
`define ECF_ST_LEAD       2'h1
`define ECF_ST_ENGAGED    2'h2
`define ECF_DIV_MIN       10'h005
`define ECF_DIV_MAX       10'h2D0
`define ECF_DO_CAM_AREA   5'h18
`define ECF_CLK_MHZ       200
`define ECF_TICK_US       1000
`define ECF_TICK_CYCLES   (`ECF_TICK_US * `ECF_CLK_MHZ)
`define ECF_MPOS_RST      32'h00000000
`endif
